// ---- bench/watchdog_interval_timer_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module watchdog_interval_timer_bench
   import wdt_pkg::*;
();
   logic       mclk;
   logic       rst_n;
   cpu_req_t   cpu_req;
   logic [7:0] cpu_rdata;
   logic       interval_interrupt;
   logic       chip_reset;
   logic       reset_output_pin_n;
   logic [7:0] rv;
   logic [7:0] r1;
   int         num_errors = 0;
   int         n_compared = 0;
   int         k;
   int         divs[8] = '{2, 32, 64, 128, 256, 512, 2048, 4096};

   watchdog_interval_timer DUT (.mclk(mclk), .rst_n(rst_n), .cpu_req(cpu_req),
      .cpu_rdata(cpu_rdata), .interval_interrupt(interval_interrupt),
      .chip_reset(chip_reset), .reset_output_pin_n(reset_output_pin_n));
   wdt_cpu_model u_cpu (.mclk(mclk), .cpu_rdata(cpu_rdata), .cpu_req(cpu_req));

   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end

   task automatic check(input string n, input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", n, exp, seen);
      end
   endtask
   task automatic test_done();
      $display("compared %0d errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      u_cpu.bus(a, 1'b1, 1'b1, d, rv);
   endtask
   task automatic rdc(input string n, input logic [15:0] a, input logic [7:0] e);
      u_cpu.bus(a, 1'b0, 1'b0, 16'h0000, rv);
      check(n, rv, e);
   endtask
   // bounded wait on chip_reset (s=0) or the interrupt (s=1)
   task automatic wait_on(input logic s, input logic v, input int lim, input string n);
      for (k = 0; k < lim && (s ? interval_interrupt : chip_reset) !== v; k++) @(negedge mclk);
      check(n, {7'h00, s ? interval_interrupt : chip_reset}, {7'h00, v});
   endtask

   // the longest path is the clock select sweep, about 29k cycles
   initial begin
      repeat (40000) @(posedge mclk);
      num_errors++;
      test_done();
   end

   initial begin
      rst_n = 1'b0;
      repeat (2) @(negedge mclk);
      rst_n = 1'b1;
      rdc("status", 16'hffab, 8'h3f);
      rdc("ctrl", 16'hffa8, 8'h18);
      rdc("gap", 16'hffaa, 8'h00);
      wr(16'hffa8, 16'h5a33);
      rdc("held", 16'hffa9, 8'h00);
      wr(16'hffa8, 16'ha53f);
      wr(16'hffa8, 16'h5a33);
      rdc("count", 16'hffa9, 8'h33);
      u_cpu.bus(16'hffa8, 1'b1, 1'b0, 16'h5a55, rv);
      wr(16'hffa8, 16'h3c77);
      rdc("count_kept", 16'hffa9, 8'h33);
      rdc("ctrl_set", 16'hffa8, 8'h3f);
      for (int i = 0; i < 8; i++) begin
         // stop first with the old select, then change it while stopped
         wr(16'hffa8, {8'ha5, 5'h03, 3'(i + 7)});
         wr(16'hffa8, {8'ha5, 5'h03, i[2:0]});
         wr(16'hffa8, {8'ha5, 5'h07, i[2:0]});
         repeat (4 * divs[i] - 1) @(negedge mclk);
         rdc("rate", 16'hffa9, 8'h04);
      end
      wr(16'hffa8, 16'ha507);
      wr(16'hffa8, 16'ha500);
      wr(16'hffa8, 16'ha520);
      // two writes of opposite tick phase: one meets a tick, which is lost
      wr(16'hffa8, 16'h5a10);
      u_cpu.bus(16'hffa9, 1'b0, 1'b0, 16'h0000, r1);
      @(negedge mclk);
      wr(16'hffa8, 16'h5a10);
      u_cpu.bus(16'hffa9, 1'b0, 1'b0, 16'h0000, rv);
      check("write_beats_tick", r1 + rv, 8'h21);
      wr(16'hffa8, 16'h5afe);
      wait_on(1'b1, 1'b1, 12, "irq_set");
      wr(16'hffa8, 16'ha520);
      check("irq_kept", {7'h00, interval_interrupt}, 8'h01);
      rdc("ctrl_ovf", 16'hffa8, 8'hb8);
      wr(16'hffa8, 16'ha520);
      check("irq_clr", {7'h00, interval_interrupt}, 8'h00);
      wr(16'hffaa, 16'h5a40);
      rdc("oe_set", 16'hffab, 8'h7f);
      wr(16'hffa8, 16'ha560);
      wr(16'hffa8, 16'h5aff);
      wait_on(1'b0, 1'b1, 12, "hold_set");
      check("pin_low", {7'h00, reset_output_pin_n}, 8'h00);
      wait_on(1'b0, 1'b0, 600, "hold_end");
      rdc("flag_kept", 16'hffab, 8'hff);
      rdc("ctrl_clr", 16'hffa8, 8'h18);
      wr(16'hffaa, 16'ha500);
      rdc("flag_clr", 16'hffab, 8'h7f);
      wr(16'hffaa, 16'h5a00);
      rdc("oe_clr", 16'hffab, 8'h3f);
      wr(16'hffa8, 16'ha560);
      wr(16'hffa8, 16'h5aff);
      wait_on(1'b0, 1'b1, 12, "hold_again");
      check("pin_idle", {7'h00, reset_output_pin_n}, 8'h01);
      rst_n = 1'b0;
      @(negedge mclk);
      rst_n = 1'b1;
      check("hold_drop", {7'h00, chip_reset}, 8'h00);
      rdc("pin_wins", 16'hffab, 8'h3f);
      test_done();
   end
endmodule // watchdog_interval_timer_bench
`default_nettype wire

// ---- bench/wdt_cpu_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module wdt_cpu_model
   import wdt_pkg::*;
(
   input  wire logic       mclk,
   input  wire logic [7:0] cpu_rdata,
   output var  cpu_req_t   cpu_req
);
   initial cpu_req = '0;
   // one access, then the bus shows garbage, not the last value
   task automatic bus(input logic [15:0] a, input logic w, input logic wd,
                      input logic [15:0] d, output logic [7:0] q);
      @(negedge mclk);
      cpu_req = '{a, w, !w, wd, d};
      @(negedge mclk);
      cpu_req = '{~a, 1'b0, 1'b0, 1'b0, ~d};
      q = cpu_rdata;
   endtask
endmodule // wdt_cpu_model
`default_nettype wire

// ---- bench/wdt_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
module wdt_properties
   import wdt_pkg::*;
(
   input wire logic       mclk,
   input wire logic       rst_n,
   input wire cpu_req_t   cpu_req,
   input wire logic [7:0] cpu_rdata,
   input wire logic       interval_interrupt,
   input wire logic       chip_reset,
   input wire logic       reset_output_pin_n
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   logic [9:0] hold_cnt;
   logic [9:0] pin_cnt;
   // decoded bus events
   wire ctrl_wr = cpu_req.wr && cpu_req.word && cpu_req.addr == 16'hffa8;
   wire rd_odd  = cpu_req.rd && !(cpu_req.addr inside {16'hffa8, 16'hffa9, 16'hffab});
   // pulse lengths, one cycle late: zero from the second cycle the pulse is absent
   always_ff @(posedge mclk) begin
      hold_cnt <= (rst_n && chip_reset) ? hold_cnt + 10'h001 : 10'h000;
      pin_cnt  <= (rst_n && !reset_output_pin_n) ? pin_cnt + 10'h001 : 10'h000;
   end
   sequence s_hold_start; $rose(chip_reset); endsequence
   sequence s_pin_start; $fell(reset_output_pin_n); endsequence
   // a pin reset cuts a pulse short, so only uncut pulses are measured
   property p_hold_len; $fell(chip_reset) && $past(rst_n) |-> hold_cnt == 10'h206; endproperty
   property p_hold_max; chip_reset |-> hold_cnt < 10'h206; endproperty
   property p_pin_len;
      $rose(reset_output_pin_n) && $past(rst_n) |-> pin_cnt == 10'h084;
   endproperty
   property p_pin_start; s_pin_start |-> s_hold_start; endproperty
   property p_pin_in_hold; !reset_output_pin_n |-> chip_reset; endproperty
   property p_irq_quiet; s_hold_start |=> !interval_interrupt [*8]; endproperty
   property p_irq_clear; $fell(interval_interrupt) |-> $past(ctrl_wr); endproperty
   property p_unmapped; rd_odd |=> cpu_rdata == 8'h00; endproperty
   property p_rsv; cpu_req.rd && cpu_req.addr == 16'hffab |=> cpu_rdata[5:0] == 6'h3f; endproperty
   property p_pin_reset;
      $rose(rst_n) |-> !chip_reset && reset_output_pin_n && cpu_rdata == 8'h00;
   endproperty
   a_hold_len: assert property (p_hold_len) else $error("chip reset length wrong");
   a_hold_max: assert property (p_hold_max) else $error("chip reset too long");
   a_pin_len: assert property (p_pin_len) else $error("reset pin pulse length wrong");
   a_pin_start: assert property (p_pin_start) else $error("pin pulse not with reset");
   a_pin_in_hold: assert property (p_pin_in_hold) else $error("pin low outside reset");
   a_irq_quiet: assert property (p_irq_quiet) else $error("interrupt in watchdog reset");
   a_irq_clear: assert property (p_irq_clear) else $error("interrupt dropped unasked");
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   a_rsv: assert property (p_rsv) else $error("reserved status bits not one");
   a_pin_reset: assert property (p_pin_reset) else $error("outputs not idle after reset");
endmodule // wdt_properties

bind watchdog_interval_timer wdt_properties u_props (.mclk(mclk), .rst_n(rst_n),
   .cpu_req(cpu_req), .cpu_rdata(cpu_rdata), .interval_interrupt(interval_interrupt),
   .chip_reset(chip_reset), .reset_output_pin_n(reset_output_pin_n));
`default_nettype wire

// ---- verilog/watchdog_interval_timer.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "wdt_consts.svh"

module watchdog_interval_timer
   import wdt_pkg::*;
(
   input  wire logic     mclk,
   input  wire logic     rst_n,
   input  wire cpu_req_t cpu_req,
   output logic [7:0]    cpu_rdata,
   output logic          interval_interrupt,
   output logic          chip_reset,
   output logic          reset_output_pin_n
);

   // ****************************************************************
   // helpers
   // ****************************************************************

   // low-bit mask whose all-ones state marks a counter clock
   function automatic logic [11:0] div_mask(input logic [2:0] sel);
      logic [11:0] m;
      m = `WDT_DIV2_MASK;
      unique case (sel)
         3'h0: m = `WDT_DIV2_MASK;
         3'h1: m = `WDT_DIV32_MASK;
         3'h2: m = `WDT_DIV64_MASK;
         3'h3: m = `WDT_DIV128_MASK;
         3'h4: m = `WDT_DIV256_MASK;
         3'h5: m = `WDT_DIV512_MASK;
         3'h6: m = `WDT_DIV2048_MASK;
         3'h7: m = `WDT_DIV4096_MASK;
      endcase
      return m;
   endfunction

   // ****************************************************************
   // state
   // ****************************************************************
   localparam logic [9:0] INT_RST_LEN = 10'(`WDT_INT_RST_CYCLES);
   localparam logic [7:0] EXT_RST_LEN = 8'(`WDT_EXT_RST_CYCLES);

   ctrl_t       ctrl_reg;
   ctrl_t       ctrl_next;
   logic [7:0]  count_reg;
   logic [7:0]  count_next;
   logic [11:0] presc_reg;
   logic        wd_flag_reg;
   logic        wd_flag_next;
   logic        out_en_reg;
   logic        out_en_next;
   logic        clr_armed_reg;
   logic        clr_armed_next;
   logic [9:0]  int_cnt_reg;
   logic [9:0]  int_cnt_next;
   logic [7:0]  ext_cnt_reg;
   logic [7:0]  ext_cnt_next;
   logic [7:0]  rdata_reg;
   logic [7:0]  rdata_next;

   // ****************************************************************
   // write decode
   // ****************************************************************

   // byte writes never pass: a stray byte store cannot feed the dog
   wire       word_wr  = cpu_req.wr & cpu_req.word;
   wire [7:0] wr_pass  = cpu_req.wdata[15:8];
   wire [7:0] wr_low   = cpu_req.wdata[7:0];
   wire       in_rst   = (int_cnt_reg != 10'h000);
   wire       wr_ok    = word_wr & ~in_rst;
   wire       at_cc    = (cpu_req.addr == `WDT_ADDR_CTRL_CNT_WR);
   wire       at_rc    = (cpu_req.addr == `WDT_ADDR_RSTCTL_WR);

   // other passwords fall through every decode below
   wire       cnt_wr   = wr_ok & at_cc & (wr_pass == `WDT_PASS_COUNT);
   wire       ctl_wr   = wr_ok & at_cc & (wr_pass == `WDT_PASS_CTRL);
   wire       flag_clr = wr_ok & at_rc & (wr_pass == `WDT_PASS_CTRL)
                       & (wr_low == `WDT_CLEAR_DATA);
   wire       oe_wr    = wr_ok & at_rc & (wr_pass == `WDT_PASS_COUNT);

   // ****************************************************************
   // read decode
   // ****************************************************************
   wire rd_ctrl = cpu_req.rd & (cpu_req.addr == `WDT_ADDR_CTRL_RD);
   wire rd_cnt  = cpu_req.rd & (cpu_req.addr == `WDT_ADDR_COUNT_RD);
   wire rd_rst  = cpu_req.rd & (cpu_req.addr == `WDT_ADDR_RSTCTL_RD);
   wire [7:0] ctrl_view = {ctrl_reg.overflow_flag,
                           ctrl_reg.watchdog_or_interval_select,
                           ctrl_reg.count_enable,
                           `WDT_CTRL_RSV_VAL,
                           ctrl_reg.clock_select_field};
   wire [7:0] rst_view  = {wd_flag_reg, out_en_reg, `WDT_RSTCTL_RSV_VAL};

   // ****************************************************************
   // counting
   // ****************************************************************

   // clock select changed on the fly may drop or add one tick;
   // software is expected to stop the counter first
   wire tick     = &(presc_reg | ~div_mask(ctrl_reg.clock_select_field));
   wire run      = ctrl_reg.count_enable;
   wire overflow = run & tick & ~cnt_wr & ~in_rst
                 & (count_reg == 8'hff);
   wire wd_mode  = ctrl_reg.watchdog_or_interval_select;
   wire wd_fire  = overflow & wd_mode;

   // counter: reset, then enable, then write, then increment
   always_comb begin
      count_next = count_reg;
      if (in_rst || !run) begin
         count_next = `WDT_COUNT_RST;
      end else if (cnt_wr) begin
         count_next = wr_low;
      end else if (tick) begin
         count_next = count_reg + 8'h01;
      end
   end

   // ****************************************************************
   // control/status register
   // ****************************************************************

   // a read that sees the flag set arms the clear
   assign clr_armed_next = in_rst ? 1'b0 :
                           (rd_ctrl & ctrl_reg.overflow_flag) ? 1'b1 :
                           ctl_wr ? 1'b0 : clr_armed_reg;

   always_comb begin
      ctrl_next = ctrl_reg;
      if (in_rst) begin
         ctrl_next.overflow_flag               = 1'b0;
         ctrl_next.watchdog_or_interval_select = 1'b0;
         ctrl_next.count_enable                = 1'b0;
         ctrl_next.clock_select_field          = `WDT_CKS_RST;
      end else begin
         if (ctl_wr) begin
            ctrl_next.watchdog_or_interval_select = wr_low[6];
            ctrl_next.count_enable                = wr_low[5];
            ctrl_next.clock_select_field          = wr_low[2:0];
            // only a zero after a read of one clears the flag
            if (!wr_low[`WDT_FLAG_BIT] && clr_armed_reg) begin
               ctrl_next.overflow_flag = 1'b0;
            end
         end
         // a fresh overflow outranks a clear in the same cycle
         if (overflow) begin
            ctrl_next.overflow_flag = 1'b1;
         end
      end
      ctrl_next.rsv = `WDT_CTRL_RSV_VAL;
   end

   // ****************************************************************
   // reset cause register
   // ****************************************************************

   // the chip reset leaves both bits alone; only rst_n or a software write clears them
   assign wd_flag_next = wd_fire ? 1'b1 :
                         flag_clr ? 1'b0 : wd_flag_reg;
   assign out_en_next  = oe_wr ? wr_low[`WDT_OUT_EN_BIT] : out_en_reg;

   // ****************************************************************
   // reset pulse timers
   // ****************************************************************
   assign int_cnt_next = wd_fire ? INT_RST_LEN :
                         in_rst ? int_cnt_reg - 10'h001 : int_cnt_reg;
   assign ext_cnt_next = (wd_fire && out_en_reg) ? EXT_RST_LEN :
                         (ext_cnt_reg != 8'h00) ? ext_cnt_reg - 8'h01 :
                         ext_cnt_reg;

   // ****************************************************************
   // read data
   // ****************************************************************

   // unread cycles hold the last value so the bus sees no glitch
   assign rdata_next = rd_ctrl ? ctrl_view :
                       rd_cnt  ? count_reg :
                       rd_rst  ? rst_view  :
                       cpu_req.rd ? `WDT_UNMAPPED_RD : rdata_reg;

   // ****************************************************************
   // registers, pin reset first
   // ****************************************************************

   // rst_n is tested ahead of the overflow path, so a pin reset
   // arriving together with a watchdog reset counts as a pin reset
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         ctrl_reg      <= '{1'b0, 1'b0, 1'b0, `WDT_CTRL_RSV_VAL, `WDT_CKS_RST};
         count_reg     <= `WDT_COUNT_RST;
         presc_reg     <= 12'h000;
         wd_flag_reg   <= 1'b0;
         out_en_reg    <= 1'b0;
         clr_armed_reg <= 1'b0;
         int_cnt_reg   <= 10'h000;
         ext_cnt_reg   <= 8'h00;
         rdata_reg     <= 8'h00;
      end else begin
         ctrl_reg      <= ctrl_next;
         count_reg     <= count_next;
         presc_reg     <= presc_reg + 12'h001;
         wd_flag_reg   <= wd_flag_next;
         out_en_reg    <= out_en_next;
         clr_armed_reg <= clr_armed_next;
         int_cnt_reg   <= int_cnt_next;
         ext_cnt_reg   <= ext_cnt_next;
         rdata_reg     <= rdata_next;
      end
   end

   // ****************************************************************
   // outputs
   // ****************************************************************

   // interrupt follows the flag in interval mode only, so it stays up until cleared or watchdog mode is set
   assign interval_interrupt = ctrl_reg.overflow_flag & ~wd_mode;
   assign chip_reset         = in_rst;
   assign reset_output_pin_n = (ext_cnt_reg == 8'h00);
   assign cpu_rdata          = rdata_reg;

endmodule // watchdog_interval_timer
`default_nettype wire

// ---- verilog/wdt_consts.svh ----
`ifndef WDT_CONSTS_SVH
`define WDT_CONSTS_SVH

// ****************************************************************
// addresses, low 16 bits
// ****************************************************************
`define WDT_ADDR_CTRL_CNT_WR   16'hffa8
`define WDT_ADDR_RSTCTL_WR     16'hffaa
`define WDT_ADDR_CTRL_RD       16'hffa8
`define WDT_ADDR_COUNT_RD      16'hffa9
`define WDT_ADDR_RSTCTL_RD     16'hffab

// ****************************************************************
// passwords and field layout
// ****************************************************************
`define WDT_PASS_COUNT         8'h5a
`define WDT_PASS_CTRL          8'ha5
`define WDT_CLEAR_DATA         8'h00
`define WDT_CTRL_RSV_VAL       2'h3
`define WDT_RSTCTL_RSV_VAL     6'h3f
`define WDT_OUT_EN_BIT         6
`define WDT_FLAG_BIT           7
`define WDT_UNMAPPED_RD        8'h00

// ****************************************************************
// reset values
// ****************************************************************
`define WDT_COUNT_RST          8'h00
`define WDT_CKS_RST            3'h0

// ****************************************************************
// prescaler masks, low bits all ones on a tick
// ****************************************************************
`define WDT_DIV2_MASK          12'h001
`define WDT_DIV32_MASK         12'h01f
`define WDT_DIV64_MASK         12'h03f
`define WDT_DIV128_MASK        12'h07f
`define WDT_DIV256_MASK        12'h0ff
`define WDT_DIV512_MASK        12'h1ff
`define WDT_DIV2048_MASK       12'h7ff
`define WDT_DIV4096_MASK       12'hfff

// ****************************************************************
// timing, one state is one mclk period
// ****************************************************************
`define WDT_CYCLES_PER_STATE   1
`define WDT_INT_RST_STATES     518
`define WDT_EXT_RST_STATES     132
`define WDT_INT_RST_CYCLES     (`WDT_INT_RST_STATES * `WDT_CYCLES_PER_STATE)
`define WDT_EXT_RST_CYCLES     (`WDT_EXT_RST_STATES * `WDT_CYCLES_PER_STATE)

`endif

// ---- verilog/wdt_pkg.sv ----
`default_nettype none
package wdt_pkg;

   // ****************************************************************
   // cpu bus request, one cycle per access
   // ****************************************************************
   typedef struct packed {
      logic [15:0] addr;
      logic        wr;
      logic        rd;
      logic        word;
      logic [15:0] wdata;
   } cpu_req_t;

   // ****************************************************************
   // control/status register layout
   // ****************************************************************
   typedef struct packed {
      logic       overflow_flag;
      logic       watchdog_or_interval_select;
      logic       count_enable;
      logic [1:0] rsv;
      logic [2:0] clock_select_field;
   } ctrl_t;

endpackage
`default_nettype wire
